// >>> design/agr_pkg.sv
// Package: register map, field layout and decode constants of the gain and rate control block
package agr_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_MONITOR_MUX_CONTROL = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_RATE_CONTROL = 4'h3;
	localparam int CLK_FLAG_BIT = 7;
	localparam int MON_SEL_MSB = 2;
	localparam int MON_SEL_LSB = 0;
	localparam int GAIN_MSB = 6;
	localparam int GAIN_LSB = 4;
	localparam int RATE_MSB = 3;
	localparam int RATE_LSB = 0;
	localparam logic [2:0] MON_SEL_RESET = 3'h0;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [3:0] RATE_RESET = 4'h0;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	localparam logic [2:0] MON_NORMAL = 3'h0;
	localparam logic [2:0] MON_OFFSET = 3'h1;
	localparam logic [2:0] MON_GAIN_REF = 3'h2;
	localparam logic [2:0] MON_TEMP = 3'h3;
	localparam logic [2:0] GAIN_UNITY = 3'h0;
	localparam logic [3:0] RATE_LAST_LISTED = 4'h8;
	localparam int ROUTE_W = 4;
	localparam logic [ROUTE_W-1:0] ROUTE_NORMAL = 4'h1;
	localparam logic [ROUTE_W-1:0] ROUTE_OFFSET = 4'h2;
	localparam logic [ROUTE_W-1:0] ROUTE_GAIN_REF = 4'h4;
	localparam logic [ROUTE_W-1:0] ROUTE_TEMP = 4'h8;
	localparam logic [ROUTE_W-1:0] ROUTE_OPEN = 4'h0;
	localparam int SPS_W = 11;
	localparam logic [SPS_W-1:0] SPS_MAX = 11'h7D0;
	localparam logic [SPS_W-1:0] SPS_MIN = 11'h005;
	typedef logic [SPS_W-1:0] agr_sps_t;

	// Samples per second for one rate code
	function automatic agr_sps_t agr_rate_sps(input logic [3:0] code);
		case (code)
			4'h0: agr_rate_sps = 11'h005;
			4'h1: agr_rate_sps = 11'h00A;
			4'h2: agr_rate_sps = 11'h014;
			4'h3: agr_rate_sps = 11'h028;
			4'h4: agr_rate_sps = 11'h050;
			4'h5: agr_rate_sps = 11'h0A0;
			4'h6: agr_rate_sps = 11'h140;
			4'h7: agr_rate_sps = 11'h280;
			4'h8: agr_rate_sps = 11'h3E8;
			default: agr_rate_sps = SPS_MAX;
		endcase
	endfunction

	// Gain multiplier for one gain code
	function automatic logic [7:0] agr_gain_factor(input logic [2:0] code);
		agr_gain_factor = 8'h01 << code;
	endfunction
endpackage

// >>> design/agr_dec_if.sv
// Interface: settings to the decoder and decoded path, gain and rate back
`timescale 1ns/1ps
interface agr_dec_if;
	logic [2:0] monitor_select;
	logic [2:0] amp_gain_code;
	logic [3:0] output_rate_code;
	logic [agr_pkg::ROUTE_W-1:0] route;
	logic bias_block;
	logic [2:0] eff_gain_code;
	logic [7:0] gain_factor;
	logic [agr_pkg::SPS_W-1:0] rate_sps;
	modport ctrl (output monitor_select, output amp_gain_code, output output_rate_code,
		input route, input bias_block, input eff_gain_code, input gain_factor, input rate_sps);
	modport dec (input monitor_select, input amp_gain_code, input output_rate_code,
		output route, output bias_block, output eff_gain_code, output gain_factor, output rate_sps);
endinterface

// >>> design/agr_decode.sv
// Decoder: monitor path, effective gain and output rate from register settings
`timescale 1ns/1ps
module agr_decode (
	agr_dec_if.dec d
);
	import agr_pkg::*;

	always_comb begin
		case (d.monitor_select)
			MON_NORMAL: d.route = ROUTE_NORMAL;
			MON_OFFSET: d.route = ROUTE_OFFSET;
			MON_GAIN_REF: d.route = ROUTE_GAIN_REF;
			MON_TEMP: d.route = ROUTE_TEMP;
			// Undefined codes leave every path open rather than guess one
			default: d.route = ROUTE_OPEN;
		endcase
		d.bias_block = (d.monitor_select != MON_NORMAL);
		if (d.monitor_select == MON_GAIN_REF || d.monitor_select == MON_TEMP) begin
			d.eff_gain_code = GAIN_UNITY;
		end else begin
			d.eff_gain_code = d.amp_gain_code;
		end
		d.gain_factor = agr_gain_factor(d.eff_gain_code);
		d.rate_sps = agr_rate_sps(d.output_rate_code);
	end
endmodule

// >>> design/agr_control.sv
// Top: monitor mux and gain/rate control registers with decoded outputs
// Function
// - Bit 7 of the monitor mux control register reads 0 for internal oscillator and 1 for external clock.
// - Bits 2:0 of the monitor mux control register are a read/write monitor select resetting to zero.
// - Monitor select 000 routes the external analog inputs to the converter and is the default.
// - Monitor select 001 disconnects the inputs and ties both converter inputs to mid-supply.
// - Monitor select 010 connects the converter inputs to the voltage reference for gain calibration.
// - Monitor select 011 connects the converter inputs to the temperature diode.
// - Any nonzero monitor select overrides the input bias enables so they have no effect.
// - Codes 010 and 011 force unity gain, codes 000 and 001 use the stored gain code.
// - Gain code in bits 6:4 selects gains 1 to 128 in powers of two, default 000.
// - Rate code in bits 3:0 selects 5 to 1000 samples per second for codes 0000 to 1000, default 0000.
// - Rate codes 1001 to 1111 all select 2000 samples per second.
// - The gain and rate control register sits at 03h and resets to 00h.
`timescale 1ns/1ps
module agr_control (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [agr_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [agr_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic ext_clock_in,
	input wire logic [1:0] input_bias_enable_in,
	output logic [agr_pkg::DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic [agr_pkg::ROUTE_W-1:0] route_out,
	output logic [1:0] bias_en_out,
	output logic [2:0] amp_gain_code_out,
	output logic [7:0] gain_factor_out,
	output logic [agr_pkg::SPS_W-1:0] rate_sps_out
);
	import agr_pkg::*;

	logic clock_source_flag_reg;
	logic clock_source_flag_next;
	logic [2:0] monitor_select_reg;
	logic [2:0] monitor_select_next;
	logic [2:0] amp_gain_code_reg;
	logic [2:0] amp_gain_code_next;
	logic [3:0] output_rate_code_reg;
	logic [3:0] output_rate_code_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [ROUTE_W-1:0] route_reg;
	logic [ROUTE_W-1:0] route_next;
	logic [1:0] bias_reg;
	logic [1:0] bias_next;
	logic [2:0] gain_code_reg;
	logic [2:0] gain_code_next;
	logic [7:0] gain_factor_reg;
	logic [7:0] gain_factor_next;
	logic [SPS_W-1:0] rate_sps_reg;
	logic [SPS_W-1:0] rate_sps_next;
	logic [DATA_W-1:0] mux_view;
	logic [DATA_W-1:0] sys_view;

	agr_dec_if dec_bus ();

	assign dec_bus.monitor_select = monitor_select_reg;
	assign dec_bus.amp_gain_code = amp_gain_code_reg;
	assign dec_bus.output_rate_code = output_rate_code_reg;

	agr_decode u_decode (
		.d(dec_bus)
	);

	// Register state
	always_comb begin
		clock_source_flag_next = ext_clock_in;
		monitor_select_next = monitor_select_reg;
		amp_gain_code_next = amp_gain_code_reg;
		output_rate_code_next = output_rate_code_reg;
		// Only defined fields are kept, so reserved bits cannot latch written ones
		if (reg_wr_in && reg_addr_in == ADDR_MONITOR_MUX_CONTROL) begin
			monitor_select_next = reg_wdata_in[MON_SEL_MSB:MON_SEL_LSB];
		end
		if (reg_wr_in && reg_addr_in == ADDR_GAIN_RATE_CONTROL) begin
			amp_gain_code_next = reg_wdata_in[GAIN_MSB:GAIN_LSB];
			output_rate_code_next = reg_wdata_in[RATE_MSB:RATE_LSB];
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_source_flag_reg <= 1'b0;
			monitor_select_reg <= MON_SEL_RESET;
			amp_gain_code_reg <= GAIN_RESET;
			output_rate_code_reg <= RATE_RESET;
		end else begin
			clock_source_flag_reg <= clock_source_flag_next;
			monitor_select_reg <= monitor_select_next;
			amp_gain_code_reg <= amp_gain_code_next;
			output_rate_code_reg <= output_rate_code_next;
		end
	end

	// Read port
	always_comb begin
		mux_view = '0;
		mux_view[CLK_FLAG_BIT] = clock_source_flag_reg;
		mux_view[MON_SEL_MSB:MON_SEL_LSB] = monitor_select_reg;
		sys_view = '0;
		sys_view[GAIN_MSB:GAIN_LSB] = amp_gain_code_reg;
		sys_view[RATE_MSB:RATE_LSB] = output_rate_code_reg;
		rvalid_next = reg_rd_in;
		rdata_next = rdata_reg;
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_MONITOR_MUX_CONTROL: rdata_next = mux_view;
				ADDR_GAIN_RATE_CONTROL: rdata_next = sys_view;
				default: rdata_next = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Decoded outputs, registered so the analog controls never see decoder glitches
	always_comb begin
		route_next = dec_bus.route;
		bias_next = dec_bus.bias_block ? 2'h0 : input_bias_enable_in;
		gain_code_next = dec_bus.eff_gain_code;
		gain_factor_next = dec_bus.gain_factor;
		rate_sps_next = dec_bus.rate_sps;
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			route_reg <= ROUTE_NORMAL;
			bias_reg <= 2'h0;
			gain_code_reg <= GAIN_RESET;
			gain_factor_reg <= 8'h01;
			rate_sps_reg <= SPS_MIN;
		end else begin
			route_reg <= route_next;
			bias_reg <= bias_next;
			gain_code_reg <= gain_code_next;
			gain_factor_reg <= gain_factor_next;
			rate_sps_reg <= rate_sps_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;
	assign route_out = route_reg;
	assign bias_en_out = bias_reg;
	assign amp_gain_code_out = gain_code_reg;
	assign gain_factor_out = gain_factor_reg;
	assign rate_sps_out = rate_sps_reg;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	// Readback shows the clock input as sampled one edge before the read was taken
	chk_clock_flag_read: assert property (
		reg_rd_in && reg_addr_in == ADDR_MONITOR_MUX_CONTROL
		|=> reg_rdata_out[CLK_FLAG_BIT] == $past(ext_clock_in, 2))
		else $error("clock source flag does not follow clock input");
	chk_select_write: assert property (
		reg_wr_in && reg_addr_in == ADDR_MONITOR_MUX_CONTROL
		|=> monitor_select_reg == $past(reg_wdata_in[MON_SEL_MSB:MON_SEL_LSB]))
		else $error("monitor select does not hold written value");
	chk_route_normal: assert property (
		monitor_select_reg == MON_NORMAL |=> route_out == ROUTE_NORMAL)
		else $error("normal path not routed");
	chk_route_offset: assert property (
		monitor_select_reg == MON_OFFSET |=> route_out == ROUTE_OFFSET)
		else $error("offset short not routed");
	chk_route_ref: assert property (
		monitor_select_reg == MON_GAIN_REF |=> route_out == ROUTE_GAIN_REF)
		else $error("reference path not routed");
	chk_route_temp: assert property (
		monitor_select_reg == MON_TEMP |=> route_out == ROUTE_TEMP)
		else $error("temperature diode not routed");
	chk_bias_block: assert property (
		monitor_select_reg != MON_NORMAL |=> bias_en_out == 2'h0)
		else $error("bias active while monitor selected");
	chk_bias_pass: assert property (
		monitor_select_reg == MON_NORMAL |=> bias_en_out == $past(input_bias_enable_in))
		else $error("bias enable not passed in normal mode");
	chk_gain_force: assert property (
		monitor_select_reg == MON_GAIN_REF || monitor_select_reg == MON_TEMP
		|=> amp_gain_code_out == GAIN_UNITY && gain_factor_out == 8'h01)
		else $error("gain not forced to unity");
	chk_gain_stored: assert property (
		monitor_select_reg == MON_NORMAL || monitor_select_reg == MON_OFFSET
		|=> gain_factor_out == (8'h01 << $past(amp_gain_code_reg)))
		else $error("gain factor mismatches stored code");
	chk_rate_listed: assert property (
		output_rate_code_reg == RATE_LAST_LISTED |=> rate_sps_out == 11'h3E8)
		else $error("rate code 8 not 1000 SPS");
	chk_rate_slow: assert property (
		output_rate_code_reg == 4'h0 |=> rate_sps_out == SPS_MIN)
		else $error("rate code 0 not 5 SPS");
	chk_rate_max: assert property (
		output_rate_code_reg > RATE_LAST_LISTED |=> rate_sps_out == SPS_MAX)
		else $error("high rate codes not 2000 SPS");
	chk_sys_read: assert property (
		reg_rd_in && reg_addr_in == ADDR_GAIN_RATE_CONTROL
		|=> reg_rvalid_out && reg_rdata_out == {1'b0, $past(amp_gain_code_reg), $past(output_rate_code_reg)})
		else $error("gain rate register read mismatch");
	chk_reserved_zero: assert property (
		reg_rd_in && reg_addr_in == ADDR_MONITOR_MUX_CONTROL |=> reg_rdata_out[6:3] == 4'h0)
		else $error("reserved bits read nonzero");

	cov_offset_sel: cover property (monitor_select_reg == MON_OFFSET ##1 route_out == ROUTE_OFFSET);
	cov_temp_force: cover property (monitor_select_reg == MON_TEMP && amp_gain_code_reg != GAIN_UNITY);
	cov_rate_max: cover property (output_rate_code_reg == 4'hF ##1 rate_sps_out == SPS_MAX);
	cov_gain_revert: cover property (monitor_select_reg == MON_GAIN_REF ##1 monitor_select_reg == MON_NORMAL);
endmodule

// >>> test/agr_host_model.sv
// Host model: drives single-byte register reads and writes on the control strobe bus
`timescale 1ns/1ps
module agr_host_model (
	input wire logic mclk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic wr_out,
	output logic rd_out,
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out
);
	import agr_pkg::*;
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 4'h0;
		wdata_out = 8'h00;
	end
	// Reserved bits leave as zero unless raw asks for a deliberate violation
	task automatic write_reg(input logic [3:0] a, input logic [7:0] v, input bit raw);
		@(posedge mclk_in);
		#1;
		wr_out = 1'b1;
		addr_out = a;
		wdata_out = raw ? v : (a == ADDR_MONITOR_MUX_CONTROL ? v & 8'h07 : v & 8'h7F);
		@(posedge mclk_in);
		#1;
		wr_out = 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		wdata_out = ~wdata_out;
	endtask
	// Data is taken only with the valid pulse, otherwise unknown is handed back
	task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		#1;
		rd_out = 1'b1;
		addr_out = a;
		@(posedge mclk_in);
		#1;
		rd_out = 1'b0;
		v = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
	endtask
endmodule

// >>> test/testbench.sv
// Testbench: register access, monitor path, gain and rate decode checks
`timescale 1ns/1ps
module testbench;
	import agr_pkg::*;
	logic mclk_in, reset_n_in, ext_clock_in, wr, rd, rvalid;
	logic [3:0] addr, route, er;
	logic [7:0] wdata, rdata, gfac, d;
	logic [1:0] bias_in, bias;
	logic [2:0] gcode, eg;
	logic [10:0] sps;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [10:0] sps_tab [9] = '{11'h005, 11'h00A, 11'h014, 11'h028, 11'h050, 11'h0A0, 11'h140, 11'h280, 11'h3E8};

	agr_control DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .ext_clock_in(ext_clock_in),
		.input_bias_enable_in(bias_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.route_out(route), .bias_en_out(bias), .amp_gain_code_out(gcode), .gain_factor_out(gfac),
		.rate_sps_out(sps));
	agr_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
		.rd_out(rd), .addr_out(addr), .wdata_out(wdata));

	function automatic logic [10:0] exp_sps(input logic [3:0] c);
		exp_sps = (c > 4'h8) ? 11'h7D0 : sps_tab[c];
	endfunction
	task automatic check_rd(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Decoded outputs settle one edge after the register takes the write
	task automatic check_dec(input logic [3:0] r, input logic [1:0] b, input logic [2:0] gc, input logic [10:0] s);
		@(posedge mclk_in);
		#1;
		samples_checked++;
		if ({route, bias, gcode, gfac, sps} !== {r, b, gc, 8'h01 << gc, s}) begin
			fail_count++;
			$display("Error decode expected %h seen %h", {r, b, gc, 8'h01 << gc, s}, {route, bias, gcode, gfac, sps});
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		reset_n_in = 1'b0;
		ext_clock_in = 1'b0;
		bias_in = 2'b11;
		repeat (8) @(posedge mclk_in);
		#1;
		reset_n_in = 1'b1;
		check_dec(ROUTE_NORMAL, 2'b11, 3'h0, 11'h005);
		host.read_reg(ADDR_MONITOR_MUX_CONTROL, d);
		check_rd("mux reset", 8'h00, d);
		host.read_reg(ADDR_GAIN_RATE_CONTROL, d);
		check_rd("gain rate reset", 8'h00, d);
		for (int c = 0; c < 16; c++) begin
			host.write_reg(ADDR_GAIN_RATE_CONTROL, {1'b0, c[2:0], c[3:0]}, 1'b0);
			check_dec(ROUTE_NORMAL, 2'b11, c[2:0], exp_sps(c[3:0]));
			host.read_reg(ADDR_GAIN_RATE_CONTROL, d);
			check_rd("gain rate", {1'b0, c[2:0], c[3:0]}, d);
		end
		host.write_reg(ADDR_GAIN_RATE_CONTROL, 8'h58, 1'b0);
		for (int m = 0; m < 8; m++) begin
			er = (m > 3) ? ROUTE_OPEN : 4'h1 << m;
			eg = (m == 2 || m == 3) ? GAIN_UNITY : 3'h5;
			host.write_reg(ADDR_MONITOR_MUX_CONTROL, {5'h00, m[2:0]}, 1'b0);
			check_dec(er, (m == 0) ? 2'b11 : 2'b00, eg, 11'h3E8);
			host.read_reg(ADDR_MONITOR_MUX_CONTROL, d);
			check_rd("mux select", {5'h00, m[2:0]}, d);
		end
		host.write_reg(ADDR_MONITOR_MUX_CONTROL, 8'h02, 1'b0);
		check_dec(ROUTE_GAIN_REF, 2'b00, GAIN_UNITY, 11'h3E8);
		bias_in = 2'b01;
		host.write_reg(ADDR_MONITOR_MUX_CONTROL, 8'h00, 1'b0);
		check_dec(ROUTE_NORMAL, 2'b01, 3'h5, 11'h3E8);
		ext_clock_in = 1'b1;
		host.write_reg(ADDR_MONITOR_MUX_CONTROL, 8'hFD, 1'b1);
		host.read_reg(ADDR_MONITOR_MUX_CONTROL, d);
		check_rd("mux reserved", 8'h85, d);
		ext_clock_in = 1'b0;
		host.read_reg(ADDR_MONITOR_MUX_CONTROL, d);
		check_rd("clock flag", 8'h05, d);
		host.write_reg(ADDR_GAIN_RATE_CONTROL, 8'hFF, 1'b1);
		host.write_reg(4'h4, 8'h11, 1'b1);
		host.read_reg(ADDR_GAIN_RATE_CONTROL, d);
		check_rd("gain rate reserved", 8'h7F, d);
		host.read_reg(4'h5, d);
		check_rd("unmapped", UNMAPPED_READ, d);
		reset_n_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		reset_n_in = 1'b1;
		host.read_reg(ADDR_GAIN_RATE_CONTROL, d);
		check_rd("gain rate rereset", 8'h00, d);
		check_dec(ROUTE_NORMAL, 2'b01, 3'h0, 11'h005);
		summarize();
	end
endmodule
